/* File: rtl/udv_pkg.sv */
// shared constants, types and helpers for the up/down volume step control
package udv_pkg;

   // gain index layout: 0 is mute, 1..31 map to -40 dB .. +20 dB in 2 dB steps
   localparam int          UDV_IDX_W       = 5;
   localparam logic [4:0]  UDV_MUTE_IDX    = 5'h00;
   localparam logic [4:0]  UDV_MAX_IDX     = 5'h1F;
   localparam logic [4:0]  UDV_IDX_ONE     = 5'h01;

   // gain in dB, signed byte
   localparam int          UDV_DB_W        = 8;
   localparam logic [7:0]  UDV_MUTE_DB     = 8'hAB;   // -85 dB
   localparam logic [7:0]  UDV_DB_OFFSET   = 8'h2A;   // 42: dB = 2*idx - 42
   localparam logic [7:0]  UDV_SE_DROP_DB  = 8'h06;   // single-ended drops 6 dB

   // control clock edges per step
   localparam logic [1:0]  UDV_CYC_LAST    = 2'h3;    // fourth edge completes a step
   localparam logic [1:0]  UDV_CYC_ZERO    = 2'h0;

   // auto-repeat timing, figured at the recommended oscillator rate
   localparam int          UDV_REF_CLK_HZ  = 100;
   localparam int          UDV_EDGES_STEP  = 4;
   localparam int          UDV_GAP2_MS     = 400;
   localparam int          UDV_GAP3_MS     = 200;
   localparam int          UDV_GAP4_MS     = 120;
   localparam int          UDV_GAP5_MS     = 80;
   localparam int          UDV_HOLD_W      = 6;
   // extra hold-off edges beyond the four counted edges of each gap
   localparam logic [5:0]  UDV_HOLD_GAP2   =
      6'(UDV_GAP2_MS * UDV_REF_CLK_HZ / 1000 - UDV_EDGES_STEP);
   localparam logic [5:0]  UDV_HOLD_GAP3   =
      6'(UDV_GAP3_MS * UDV_REF_CLK_HZ / 1000 - UDV_EDGES_STEP);
   localparam logic [5:0]  UDV_HOLD_GAP4   =
      6'(UDV_GAP4_MS * UDV_REF_CLK_HZ / 1000 - UDV_EDGES_STEP);
   localparam logic [5:0]  UDV_HOLD_GAP5   =
      6'(UDV_GAP5_MS * UDV_REF_CLK_HZ / 1000 - UDV_EDGES_STEP);
   localparam logic [5:0]  UDV_HOLD_NONE   = 6'h00;
   localparam logic [5:0]  UDV_HOLD_ONE    = 6'h01;

   // auto-repeat stage, Gray coded along the hold sequence
   typedef enum logic [2:0] {
      UDV_STG_FIRST  = 3'h0,
      UDV_STG_SECOND = 3'h1,
      UDV_STG_THIRD  = 3'h3,
      UDV_STG_FOURTH = 3'h2,
      UDV_STG_FIFTH  = 3'h6,
      UDV_STG_RUN    = 3'h7
   } udv_stage_t;

   // one sample of the request pins, taken at a control clock rising edge
   typedef struct packed {
      logic rise;
      logic up_req;
      logic down_req;
      logic held;
   } udv_sample_t;

   // gain in dB for an index and output topology
   function automatic logic [7:0] udv_gain_db(input logic [4:0] idx, input logic se);
      logic [7:0] bridged_load_mode;
      bridged_load_mode = (idx == UDV_MUTE_IDX) ? UDV_MUTE_DB : 8'({3'h0, idx, 1'b0} - UDV_DB_OFFSET);
      return se ? 8'(bridged_load_mode - UDV_SE_DROP_DB) : bridged_load_mode;
   endfunction : udv_gain_db

endpackage : udv_pkg

/* File: rtl/udv_edge.sv */
// control clock edge detector and request pin sampler
`timescale 1ns/1ps
module udv_edge
   import udv_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ctrl_clk,
   input  wire logic         up_n,
   input  wire logic         down_n,
   output udv_sample_t       smp
);
   logic ctrl_prev_reg;

   // remember the last control clock level to find rising edges
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ctrl_prev_reg <= 1'b0;
      else
         ctrl_prev_reg <= ctrl_clk;
   end

   // exactly one pin low counts as a request; both low is no request
   wire rise_w = ctrl_clk & ~ctrl_prev_reg;       // R11 R12
   wire up_w   = ~up_n & down_n;
   wire down_w = ~down_n & up_n;

   // one driver for the whole sample so no member has a second writer
   assign smp = '{rise: rise_w, up_req: up_w, down_req: down_w, held: up_w | down_w};

   chk_rise_single: assert property (@(posedge clk) disable iff (!rst_n) // R11
      smp.rise |=> !smp.rise)
      else $error("control clock rise seen on two cycles in a row");

endmodule : udv_edge

/* File: rtl/udv_holdoff.sv */
// auto-repeat hold-off stage and delay counter
`timescale 1ns/1ps
module udv_holdoff
   import udv_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         edge_rise,
   input  wire logic         held,
   input  wire logic         ext_mode,
   input  wire logic         step,
   output logic              busy
);
   udv_stage_t  stage_reg;
   udv_stage_t  stage_next;
   logic [5:0]  hold_reg;
   logic [5:0]  hold_next;
   logic [5:0]  gap_load;

   // hold-off to insert after a step taken in the current stage
   always_comb
   begin
      case (stage_reg)
         UDV_STG_FIRST:  gap_load = UDV_HOLD_GAP2;   // R8
         UDV_STG_SECOND: gap_load = UDV_HOLD_GAP3;   // R8
         UDV_STG_THIRD:  gap_load = UDV_HOLD_GAP4;   // R9
         UDV_STG_FOURTH: gap_load = UDV_HOLD_GAP5;   // R9
         UDV_STG_FIFTH:  gap_load = UDV_HOLD_NONE;   // R10
         UDV_STG_RUN:    gap_load = UDV_HOLD_NONE;   // R10
         default:        gap_load = UDV_HOLD_NONE;
      endcase
   end

   // stage advance on each step, saturating in the free-running stage
   always_comb
   begin
      case (stage_reg)
         UDV_STG_FIRST:  stage_next = UDV_STG_SECOND;
         UDV_STG_SECOND: stage_next = UDV_STG_THIRD;
         UDV_STG_THIRD:  stage_next = UDV_STG_FOURTH;
         UDV_STG_FOURTH: stage_next = UDV_STG_FIFTH;
         UDV_STG_FIFTH:  stage_next = UDV_STG_RUN;
         UDV_STG_RUN:    stage_next = UDV_STG_RUN;
         default:        stage_next = UDV_STG_FIRST;
      endcase
   end

   // delay counter: external clock adds none, release clears, edges count down
   assign hold_next = (ext_mode || !held)       ? UDV_HOLD_NONE :   // R16 R21
                      step                      ? gap_load :
                      (edge_rise && hold_reg != UDV_HOLD_NONE) ?
                                                  6'(hold_reg - UDV_HOLD_ONE) :
                                                  hold_reg;

   // stage and counter registers
   always_ff @(posedge clk)
   begin
      if (!rst_n || !held || ext_mode)                                  // R21
      begin
         stage_reg <= UDV_STG_FIRST;
         hold_reg  <= UDV_HOLD_NONE;
      end
      else
      begin
         stage_reg <= step ? stage_next : stage_reg;
         hold_reg  <= hold_next;
      end
   end

   assign busy = (hold_reg != UDV_HOLD_NONE);

   chk_gap_load: assert property (@(posedge clk) disable iff (!rst_n) // R8
      step && held && !ext_mode && stage_reg == UDV_STG_FIRST |=> hold_reg == 6'h24)
      else $error("second-step hold-off not 36 edges");

   chk_run_nohold: assert property (@(posedge clk) disable iff (!rst_n) // R10
      step && held && !ext_mode && (stage_reg == UDV_STG_FIFTH || stage_reg == UDV_STG_RUN)
      |=> !busy)
      else $error("hold-off loaded after the fifth step");

   chk_ext_nodelay: assert property (@(posedge clk) disable iff (!rst_n) // R16
      ext_mode |=> !busy)
      else $error("hold-off active in external clock mode");

endmodule : udv_holdoff

/* File: rtl/udv_top.sv */
// up/down volume step control: request sampling, edge counting, gain index
//
// Contract
// [R1] After power-up the gain stays at mute until a request is recognised.
// [R2] A recognised up request raises the gain by one 2 dB step.
// [R3] A recognised down request lowers the gain by one 2 dB step.
// [R4] Losing power resets the stored volume to mute.
// [R5] Internal oscillator runs at most 500 Hz, 100 Hz recommended.
// [R6] Four held control clock cycles give one step, then a hold-off.
// [R7] At 100 Hz the first step comes about 40 ms after press.
// [R8] Second step about 400 ms after first, third 200 ms after second.
// [R9] Fourth step about 120 ms after third, fifth 80 ms after fourth.
// [R10] After the fifth step, one step every four control clock cycles.
// [R11] Pins sampled on control clock rising edges; gain changes after them.
// [R12] An external clock on the clock pin replaces the internal oscillator.
// [R13] External clock at most 10 kHz, below 200 Hz recommended.
// [R14] Controller holds a request low and gives four gated pulses per step.
// [R15] Controller keeps the clock low when no change is intended.
// [R16] External clock mode inserts no hold-off; every fourth held edge steps.
// [R17] Surplus edges stay counted so the next request completes early.
// [R18] Down requests in external mode count edges like up requests.
// [R19] Topology select high gives single-ended mode, every gain 6 dB lower.
// [R20] Gain index saturates at +20 dB maximum and at the mute level.
// [R21] Releasing the request clears the cycle count and hold-off stage; the code keeps the cycle count in external clock mode.
`timescale 1ns/1ps
module udv_top
   import udv_pkg::*;
(
   input  wire logic         CORE_CLK,
   input  wire logic         RST_N,
   input  wire logic         CTRL_CLK,
   input  wire logic         EXT_CLK_MODE,
   input  wire logic         UP_REQ_N,
   input  wire logic         DOWN_REQ_N,
   input  wire logic         OUTPUT_TOPOLOGY_SELECT,
   output logic [4:0]        GAIN_INDEX,
   output logic [7:0]        GAIN_DB,
   output logic              SINGLE_ENDED_MODE,
   output logic              STEP_PULSE,
   output logic              STEP_UP
);
   udv_sample_t smp;
   logic        busy;
   logic [1:0]  cyc_cnt_reg;
   logic [1:0]  cyc_cnt_next;
   logic [4:0]  gain_idx_reg;
   logic [4:0]  gain_idx_next;
   logic [7:0]  gain_db_reg;
   logic        se_reg;
   logic        step_pulse_reg;
   logic        step_up_reg;

   // control clock edge detect and request sampling at each rising edge
   udv_edge u_edge (
      .clk       (CORE_CLK),
      .rst_n     (RST_N),
      .ctrl_clk  (CTRL_CLK),
      .up_n      (UP_REQ_N),
      .down_n    (DOWN_REQ_N),
      .smp       (smp)
   );

   // an edge is counted when a request is held and no hold-off is pending
   wire count_edge = smp.rise & smp.held & ~busy;                       // R6 R11
   wire cyc_done   = count_edge & (cyc_cnt_reg == UDV_CYC_LAST);        // R6 R7
   wire step_fire  = cyc_done;
   wire do_up      = step_fire & smp.up_req;                            // R2
   wire do_down    = step_fire & smp.down_req;                          // R3 R18
   wire at_max     = (gain_idx_reg == UDV_MAX_IDX);
   wire at_mute    = (gain_idx_reg == UDV_MUTE_IDX);

   // auto-repeat hold-off, bypassed when the clock comes from outside
   udv_holdoff u_holdoff (
      .clk       (CORE_CLK),
      .rst_n     (RST_N),
      .edge_rise (smp.rise),
      .held      (smp.held),
      .ext_mode  (EXT_CLK_MODE),
      .step      (step_fire),
      .busy      (busy)
   );

   // cycle counter: internal mode clears on release, external keeps surplus edges
   assign cyc_cnt_next = (!EXT_CLK_MODE && !smp.held) ? UDV_CYC_ZERO :  // R21
                         count_edge ? 2'(cyc_cnt_reg + 2'h1) :          // R16 R17
                                      cyc_cnt_reg;

   // gain index moves one step, saturating at both ends
   assign gain_idx_next = (do_up && !at_max)    ? 5'(gain_idx_reg + UDV_IDX_ONE) :  // R2 R20
                          (do_down && !at_mute) ? 5'(gain_idx_reg - UDV_IDX_ONE) :  // R3 R20
                                                  gain_idx_reg;

   // state and output registers; reset stands for power removal
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)                                                       // R1 R4
      begin
         cyc_cnt_reg    <= UDV_CYC_ZERO;
         gain_idx_reg   <= UDV_MUTE_IDX;
         gain_db_reg    <= UDV_MUTE_DB;
         se_reg         <= 1'b0;
         step_pulse_reg <= 1'b0;
         step_up_reg    <= 1'b0;
      end
      else
      begin
         cyc_cnt_reg    <= cyc_cnt_next;
         gain_idx_reg   <= gain_idx_next;                              // R11
         gain_db_reg    <= udv_gain_db(gain_idx_next, OUTPUT_TOPOLOGY_SELECT); // R19
         se_reg         <= OUTPUT_TOPOLOGY_SELECT;                      // R19
         step_pulse_reg <= step_fire;
         step_up_reg    <= step_fire ? smp.up_req : step_up_reg;
      end
   end

   // outputs straight from flip-flops
   assign GAIN_INDEX        = gain_idx_reg;
   assign GAIN_DB           = gain_db_reg;
   assign SINGLE_ENDED_MODE = se_reg;
   assign STEP_PULSE        = step_pulse_reg;
   assign STEP_UP           = step_up_reg;

   // mute after reset release, index stays put until a step fires
   chk_mute_reset: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R1 R4
      $rose(RST_N) |-> gain_idx_reg == UDV_MUTE_IDX)
      else $error("gain not at mute after reset");

   chk_hold_still: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R1
      !step_fire |=> gain_idx_reg == $past(gain_idx_reg))
      else $error("gain index changed without a step");

   chk_up_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R2
      do_up && !at_max |=> gain_idx_reg == 5'($past(gain_idx_reg) + 5'h01))
      else $error("up step did not add exactly one");

   chk_down_step: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R3
      do_down && !at_mute |=> gain_idx_reg == 5'($past(gain_idx_reg) - 5'h01))
      else $error("down step did not subtract exactly one");

   chk_four_edges: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R6
      count_edge && cyc_cnt_reg == 2'h3 |-> step_fire ##1 STEP_PULSE)
      else $error("fourth counted edge gave no step");

   chk_step_on_edge: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R11
      step_fire |-> smp.rise && smp.held)
      else $error("step fired away from a held rising edge");

   chk_index_sat: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R20
      (at_max && do_up) || (at_mute && do_down) |=> $stable(gain_idx_reg))
      else $error("gain index passed a limit");

   chk_release_clr: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R21
      !EXT_CLK_MODE && !smp.held |=> cyc_cnt_reg == 2'h0)
      else $error("cycle count kept after release");

   chk_surplus_kept: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R17
      EXT_CLK_MODE && !smp.held ##1 EXT_CLK_MODE |-> $stable(cyc_cnt_reg))
      else $error("external mode count lost on release");

   chk_db_map: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R19
      ##1 1'b1 |-> gain_db_reg == udv_gain_db(gain_idx_reg, se_reg))
      else $error("gain in dB does not match index and topology");

   chk_run_rate: assert property (@(posedge CORE_CLK) disable iff (!RST_N) // R16
      step_fire && EXT_CLK_MODE |=> !busy && !count_edge)
      else $error("hold-off raised unexpectedly");

endmodule : udv_top

/* File: tb/udv_ctrl_model.sv */
// push-button or controller model that drives the control clock and request pins
`timescale 1ns/1ps
module udv_ctrl_model
(
   input  wire logic clk,
   output logic      ctrl_clk,
   output logic      up_n,
   output logic      down_n
);
   // core cycles per control clock half period, kept short to shorten the run
   localparam int HALF = 2;

   // idle: clock parked low, pins at their pull-up level
   initial
   begin
      ctrl_clk = 1'b0;
      up_n     = 1'b1;
      down_n   = 1'b1;
   end

   // n gated rising edges at 50% duty, clock left low afterwards
   task automatic ticks(input int n);
      repeat (n)
      begin
         repeat (HALF) @(posedge clk);
         #1 ctrl_clk = 1'b1;
         repeat (HALF) @(posedge clk);
         #1 ctrl_clk = 1'b0;
      end
   endtask : ticks

   // pull one request pin low before the clock pulses start
   task automatic press(input logic up);
      @(posedge clk);
      #1;
      if (up)
         up_n = 1'b0;
      else
         down_n = 1'b0;
   endtask : press

   // let both pins return high
   task automatic release_pins();
      @(posedge clk);
      #1;
      up_n   = 1'b1;
      down_n = 1'b1;
   endtask : release_pins
endmodule : udv_ctrl_model

/* File: tb/test_updown_volume_step_control.sv */
// self-checking bench for the up/down volume step control
`timescale 1ns/1ps
module test_updown_volume_step_control
   import udv_pkg::*;
;
   logic       core_clk, rst_n, ext_mode, topo, ctrl_clk, up_n, down_n, ctrl_prev;
   logic [4:0] gain_index;
   logic [7:0] gain_db;
   logic       se_mode, step_pulse, step_up;
   int         error_cnt, n_checks, rise_cnt, n_steps;
   int         step_at[64];

   udv_top u_dut (.CORE_CLK(core_clk), .RST_N(rst_n), .CTRL_CLK(ctrl_clk),
      .EXT_CLK_MODE(ext_mode), .UP_REQ_N(up_n), .DOWN_REQ_N(down_n),
      .OUTPUT_TOPOLOGY_SELECT(topo), .GAIN_INDEX(gain_index), .GAIN_DB(gain_db),
      .SINGLE_ENDED_MODE(se_mode), .STEP_PULSE(step_pulse), .STEP_UP(step_up));

   udv_ctrl_model u_ctl (.clk(core_clk), .ctrl_clk(ctrl_clk), .up_n(up_n),
      .down_n(down_n));

   // 20 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // count control clock rises and note the rise count at every step pulse
   always @(posedge core_clk)
   begin
      if (ctrl_clk === 1'b1 && ctrl_prev === 1'b0)
         rise_cnt++;
      ctrl_prev = ctrl_clk;
      if (step_pulse === 1'b1)
      begin
         step_at[n_steps] = rise_cnt;
         n_steps++;
      end
   end

   // compare one value and report a mismatch
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // expected gain in dB for an index and topology
   function automatic logic [7:0] exp_db(input int idx, input logic se);
      logic [7:0] v;
      v = (idx == 0) ? UDV_MUTE_DB : 8'(2 * idx - 42);
      return se ? 8'(v - 8'h06) : v;
   endfunction : exp_db

   // one press: pin low, n control edges, release
   task automatic hold(input logic up, input int n);
      rise_cnt = 0;
      n_steps  = 0;
      u_ctl.press(up);
      u_ctl.ticks(n);
      u_ctl.release_pins();
      repeat (4) @(posedge core_clk);
      #1;
   endtask : hold

   // mute after power-up, no change without a request
   task automatic t_power_up();
      check(8'(gain_index), 8'(UDV_MUTE_IDX));
      check(gain_db, UDV_MUTE_DB);
      u_ctl.ticks(8);
      check(8'(gain_index), 8'(UDV_MUTE_IDX));
      check(8'(step_pulse), 8'h00);
      u_ctl.press(1'b1);
      u_ctl.press(1'b0);
      u_ctl.ticks(8);
      u_ctl.release_pins();
      check(8'(n_steps), 8'h00);
      check(8'(gain_index), 8'(UDV_MUTE_IDX));
   endtask : t_power_up

   // held press in internal mode: first step then shrinking hold-offs
   task automatic t_internal_repeat();
      int gap[4];
      int e;
      gap = '{UDV_GAP2_MS, UDV_GAP3_MS, UDV_GAP4_MS, UDV_GAP5_MS};
      hold(1'b1, 96);
      check(8'(n_steps), 8'h08);
      e = UDV_EDGES_STEP;
      for (int k = 0; k < 8; k++)
      begin
         check(8'(step_at[k]), 8'(e));
         e += (k < 4) ? gap[k] * UDV_REF_CLK_HZ / 1000 : UDV_EDGES_STEP;
      end
      check(8'(gain_index), 8'h08);
      check(gain_db, exp_db(8, 1'b0));
      check(8'(step_up), 8'h01);
      hold(1'b0, 44);
      check(8'(step_at[1]), 8'(44));
      check(8'(gain_index), 8'h06);
      check(8'(step_up), 8'h00);
   endtask : t_internal_repeat

   // release inside a hold-off restarts from first-step timing
   task automatic t_release_clears();
      hold(1'b1, 10);
      check(8'(n_steps), 8'h01);
      hold(1'b1, 4);
      check(8'(n_steps), 8'h01);
      check(8'(step_at[0]), 8'h04);
      check(8'(gain_index), 8'h08);
   endtask : t_release_clears

   // external clock: no hold-off, surplus edges carried to the next press
   task automatic t_external();
      ext_mode = 1'b1;
      hold(1'b1, 8);
      check(8'(n_steps), 8'h02);
      check(8'(step_at[1]), 8'h08);
      hold(1'b1, 6);
      check(8'(n_steps), 8'h01);
      hold(1'b1, 2);
      check(8'(step_at[0]), 8'h02);
      hold(1'b0, 4);
      check(8'(step_at[0]), 8'h04);
      check(8'(gain_index), 8'h0B);
   endtask : t_external

   // saturation at both ends, single-ended gain drop
   task automatic t_saturate_topology();
      hold(1'b1, 140);
      check(8'(n_steps), 8'h23);
      check(8'(gain_index), 8'(UDV_MAX_IDX));
      check(gain_db, 8'h14);
      topo = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      check(8'(se_mode), 8'h01);
      check(gain_db, 8'h0E);
      hold(1'b0, 140);
      check(8'(n_steps), 8'h23);
      check(8'(gain_index), 8'(UDV_MUTE_IDX));
      check(gain_db, exp_db(0, 1'b1));
      topo = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      check(gain_db, UDV_MUTE_DB);
   endtask : t_saturate_topology

   // power removal in mid-run returns to mute
   task automatic t_power_loss();
      hold(1'b1, 12);
      check(8'(gain_index), 8'h03);
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      check(8'(gain_index), 8'(UDV_MUTE_IDX));
      check(gain_db, UDV_MUTE_DB);
   endtask : t_power_loss

   // print counts and verdict, end the run
   task automatic complete_run();
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   // main sequence
   initial
   begin
      rst_n     = 1'b0;
      ext_mode  = 1'b0;
      topo      = 1'b0;
      ctrl_prev = 1'b0;
      error_cnt = 0;
      n_checks  = 0;
      rise_cnt  = 0;
      n_steps   = 0;
      repeat (16) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_power_up();
      t_internal_repeat();
      t_release_clears();
      t_external();
      t_saturate_topology();
      t_power_loss();
      complete_run();
   end

   // watchdog, about ten times the expected run
   initial
   begin
      #(20000 * 50);
      error_cnt++;
      complete_run();
   end
endmodule : test_updown_volume_step_control
